/* include/stc_pkg.sv */
package stc_pkg;

  // ****************************************************************
  // Frame fields
  // ****************************************************************
  // Command codes, two hex digits each.
  localparam logic [7:0] CMD_IO_DIS = 8'h90;
  localparam logic [7:0] CMD_DEVICE = 8'h92;
  localparam logic [7:0] CMD_MODE_SEL = 8'h8B;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_STATUS = 8'h12;
  localparam logic [7:0] CMD_POS_CTRL = 8'hA0;

  // Data numbers.
  localparam logic [7:0] DNO_DI_DIS = 8'h00;
  localparam logic [7:0] DNO_DI_EN = 8'h10;
  localparam logic [7:0] DNO_DO_DIS = 8'h03;
  localparam logic [7:0] DNO_DO_EN = 8'h13;
  localparam logic [7:0] DNO_WORD0 = 8'h00;
  localparam logic [7:0] DNO_WORD1 = 8'h01;
  localparam logic [7:0] DNO_DO_FORCE = 8'hA0;
  localparam logic [7:0] DNO_MODE_SEL = 8'h00;
  localparam logic [7:0] DNO_MODE_RD = 8'h12;
  localparam logic [7:0] DNO_STATUS = 8'h80;
  localparam logic [7:0] DNO_POS_CTRL = 8'h41;

  // Key and ASCII data words.
  localparam logic [31:0] IO_KEY = 32'h00001EA5;
  localparam logic [31:0] TXT_STOP = 32'h53544F50;
  localparam logic [31:0] TXT_GO = 32'h474F2020;
  localparam logic [31:0] TXT_BLANK = 32'h20202020;

  // ****************************************************************
  // Test mode codes
  // ****************************************************************
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_JOG = 3'h1;
  localparam logic [2:0] MODE_POS = 3'h2;
  localparam logic [2:0] MODE_MOTORLESS = 3'h3;
  localparam logic [2:0] MODE_DO_FORCE = 3'h4;
  localparam logic [2:0] MODE_STEP = 3'h5;

  // ****************************************************************
  // Input and status word bit positions
  // ****************************************************************
  localparam int BIT_SERVO_ENABLE = 0;
  localparam int BIT_FWD_LIMIT = 1;
  localparam int BIT_REV_LIMIT = 2;
  localparam int BIT_TORQUE_SEL = 4;
  localparam int BIT_PROP_CTRL = 5;
  localparam int BIT_ALARM_CLEAR = 6;
  localparam int BIT_DROOP_CLEAR = 7;
  localparam int BIT_FWD_START = 11;
  localparam int BIT_REV_START = 12;
  localparam int BIT_AUTO_MANUAL = 17;
  localparam int BIT_PROX_SENSOR = 18;
  localparam int BIT_OVERRIDE = 23;
  localparam int BIT_PAUSE_RESUME = 24;
  localparam int BIT_GAIN_CHANGE = 27;
  localparam int BIT_TABLE_SEL_LO = 24;
  localparam int BIT_HOMING_DONE = 17;
  // Bits that survive an input disable.
  localparam logic [31:0] KEEP_MASK = 32'h00000006;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_KHZ = 250_000;
  localparam int INACT_MS = 500;
  localparam int INACT_CYC = INACT_MS * CLK_KHZ;
  localparam int KEEPALIVE_MS = 100;
  localparam int KEEPALIVE_CYC = KEEPALIVE_MS * CLK_KHZ;

endpackage

/* include/stc_link_if.sv */
// Frame link between the host controller and the servo interpreter.
interface stc_link_if;
  // One-cycle frame strobe with its three fields.
  logic frm_valid;
  logic [7:0] frm_cmd;
  logic [7:0] frm_dno;
  logic [31:0] frm_data;
  // One-cycle reply strobe with its data word.
  logic rsp_valid;
  logic [31:0] rsp_data;

  modport dev_mp (
    input frm_valid, frm_cmd, frm_dno, frm_data,
    output rsp_valid, rsp_data
  );
  modport host_mp (
    output frm_valid, frm_cmd, frm_dno, frm_data,
    input rsp_valid, rsp_data
  );
endinterface

/* verilog/stc_device.sv */
// Overview of operation
// - Disabled inputs read OFF except stop/limits
// - 90/00 and 90/10 with key toggle inputs
// - 90/03 and 90/13 with key toggle outputs
// - 92/00 and 92/01 force input bits
// - First word bit map of input devices
// - Second word bits 24-31 select table
// - Host also drops external input it clears
// - Silence over 0.5s in test mode stops with servo lock
// - Host keeps polling during test modes; stops after a 0000 select even while motorless mode holds
// - Test mode while running coasts motor
// - 8B/00 selects test mode 1 to 5
// - 00/12 returns current test mode code
// - STOP pauses positioning with deceleration
// - GO restarts a paused positioning
// - Blank data clears remaining travel
// - Host checks homing before single-step
// - Host refuses forced output until outputs are disabled
// - Forced output drives pins as commanded
// - Mode data 0000 cancels forced output
// - Host uses test modes for checks only
// - Device bits follow last received data
module stc_device #(
  parameter int INACT_CYCLES = stc_pkg::INACT_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Frame link.
  stc_link_if.dev_mp link,
  // External pins, asynchronous to clk_sys.
  input wire logic emergency_stop_pin,
  input wire logic [31:0] input_signals_pin,
  // Drive core state, on clk_sys.
  input wire logic motor_running,
  input wire logic [31:0] drive_outputs,
  input wire logic [31:0] drive_status,
  // Effective device words toward the drive core.
  output logic emergency_stop,
  output logic [31:0] dev_word0,
  output logic [31:0] dev_word1,
  output logic analog_enable,
  // Output pins.
  output logic [31:0] output_pins,
  // Test operation state.
  output logic [2:0] test_mode,
  output logic base_off,
  output logic servo_lock_stop,
  output logic pos_paused,
  output logic pos_restart,
  output logic pos_clear
);

  // ****************************************************************
  // Frame decode
  // ****************************************************************
  // Positioning sub-state, Gray coded along idle, run, pause.
  typedef enum logic [1:0] {
    STC_POS_IDLE = 2'b00,
    STC_POS_RUN = 2'b01,
    STC_POS_PAUSE = 2'b11
  } stc_pos_type;

  stc_pos_type pos_state;
  logic in_dis;               // Input devices disabled.
  logic out_dis;              // Output devices disabled.
  logic [31:0] force_w0;      // Last word received for data number 00.
  logic [31:0] force_w1;      // Last word received for data number 01.
  logic [31:0] force_do;      // Last forced output pattern.
  logic [31:0] cnt_idle;      // Cycles since the last frame, counted in test modes only.
  logic stop_sync1;           // First stage, read only by the second.
  logic [31:0] pin_sync1;     // First stage, read only by the second.
  logic [31:0] ext_in;        // Synchronised external inputs.
  logic f_io;
  logic f_dev;
  logic f_mode;
  logic f_pos;
  logic key_ok;

  assign f_io = link.frm_valid && link.frm_cmd == stc_pkg::CMD_IO_DIS;
  assign f_dev = link.frm_valid && link.frm_cmd == stc_pkg::CMD_DEVICE;
  assign f_mode = link.frm_valid && link.frm_cmd == stc_pkg::CMD_MODE_SEL
    && link.frm_dno == stc_pkg::DNO_MODE_SEL;
  assign f_pos = link.frm_valid && link.frm_cmd == stc_pkg::CMD_POS_CTRL
    && link.frm_dno == stc_pkg::DNO_POS_CTRL;
  assign key_ok = link.frm_data == stc_pkg::IO_KEY;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Two flip-flops on every pin before any logic looks at it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_sync1 <= 1'b0;
      pin_sync1 <= 32'h00000000;
      emergency_stop <= 1'b0;
      ext_in <= 32'h00000000;
    end
    else
    begin
      stop_sync1 <= emergency_stop_pin;
      pin_sync1 <= input_signals_pin;
      emergency_stop <= stop_sync1;
      ext_in <= pin_sync1;
    end
  end

  // ****************************************************************
  // Disable and enable of inputs and outputs
  // ****************************************************************
  // A frame without the key is answered but changes nothing.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_dis <= 1'b0;
      out_dis <= 1'b0;
    end
    else if (f_io && key_ok)
    begin
      if (link.frm_dno == stc_pkg::DNO_DI_DIS)
        in_dis <= 1'b1;
      else if (link.frm_dno == stc_pkg::DNO_DI_EN)
        in_dis <= 1'b0;
      else if (link.frm_dno == stc_pkg::DNO_DO_DIS)
        out_dis <= 1'b1;
      else if (link.frm_dno == stc_pkg::DNO_DO_EN)
        out_dis <= 1'b0;
    end
  end

  // ****************************************************************
  // Forced device words
  // ****************************************************************
  // Each word is replaced whole; bits not resent fall back to OFF.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      force_w0 <= 32'h00000000;
      force_w1 <= 32'h00000000;
      force_do <= 32'h00000000;
    end
    else if (f_dev)
    begin
      if (link.frm_dno == stc_pkg::DNO_WORD0)
        force_w0 <= link.frm_data;
      else if (link.frm_dno == stc_pkg::DNO_WORD1)
        force_w1 <= link.frm_data;
      else if (link.frm_dno == stc_pkg::DNO_DO_FORCE)
        force_do <= link.frm_data;
    end
  end

  // ****************************************************************
  // Effective device words and output pins
  // ****************************************************************
  // Pins and forced bits merge; a disable keeps only the limits. The
  // second word carries the table selection bits in its top byte.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_word0 <= 32'h00000000;
      dev_word1 <= 32'h00000000;
      analog_enable <= 1'b1;
      output_pins <= 32'h00000000;
    end
    else
    begin
      dev_word0 <= (in_dis ? (ext_in & stc_pkg::KEEP_MASK) : ext_in)
        | force_w0;
      dev_word1 <= force_w1;
      analog_enable <= !in_dis;
      if (test_mode == stc_pkg::MODE_DO_FORCE)
        output_pins <= force_do;
      else if (out_dis)
        output_pins <= 32'h00000000;
      else
        output_pins <= drive_outputs;
    end
  end

  // ****************************************************************
  // Test mode selection
  // ****************************************************************
  // Motorless mode is left only by codes 1 to 5 or reset, never by 0000.
  // Codes above five are ignored and the mode is kept.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      test_mode <= stc_pkg::MODE_NORMAL;
    else if (f_mode && link.frm_data[31:3] == 29'h00000000
             && link.frm_data[2:0] <= stc_pkg::MODE_STEP)
    begin
      if (link.frm_data[2:0] != stc_pkg::MODE_NORMAL)
        test_mode <= link.frm_data[2:0];
      else if (test_mode != stc_pkg::MODE_MOTORLESS)
        test_mode <= stc_pkg::MODE_NORMAL;
    end
  end

  // Entering a test mode with the motor turning cuts the base circuit;
  // the cut holds until the motor has coasted to rest.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      base_off <= 1'b0;
    else if (f_mode && test_mode == stc_pkg::MODE_NORMAL
             && link.frm_data != 32'h00000000 && motor_running)
      base_off <= 1'b1;
    else if (!motor_running)
      base_off <= 1'b0;
  end

  // ****************************************************************
  // Communication watchdog
  // ****************************************************************
  // Any frame restarts the count; the stop holds until normal mode.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_idle <= 32'h00000000;
      servo_lock_stop <= 1'b0;
    end
    else if (test_mode == stc_pkg::MODE_NORMAL)
    begin
      cnt_idle <= 32'h00000000;
      servo_lock_stop <= 1'b0;
    end
    else if (link.frm_valid)
      cnt_idle <= 32'h00000000;
    else if (cnt_idle < INACT_CYCLES)
      cnt_idle <= cnt_idle + 32'h00000001;
    else
      servo_lock_stop <= 1'b1;
  end

  // ****************************************************************
  // Positioning pause, restart and clear
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_state <= STC_POS_IDLE;
      pos_restart <= 1'b0;
      pos_clear <= 1'b0;
    end
    else
    begin
      pos_restart <= 1'b0;
      pos_clear <= 1'b0;
      if (test_mode != stc_pkg::MODE_POS)
        pos_state <= STC_POS_IDLE;
      else
      begin
        unique case (pos_state)
          STC_POS_IDLE:
            pos_state <= STC_POS_RUN;
          STC_POS_RUN:
            if (f_pos && link.frm_data == stc_pkg::TXT_STOP)
              pos_state <= STC_POS_PAUSE;
          STC_POS_PAUSE:
            if (f_pos && link.frm_data == stc_pkg::TXT_GO)
            begin
              pos_state <= STC_POS_RUN;
              pos_restart <= 1'b1;
            end
            else if (f_pos && link.frm_data == stc_pkg::TXT_BLANK)
            begin
              // Travel is dropped; a new start runs from here.
              pos_state <= STC_POS_RUN;
              pos_clear <= 1'b1;
            end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pos_paused <= 1'b0;
    else
      pos_paused <= pos_state == STC_POS_PAUSE && !f_pos;
  end

  // ****************************************************************
  // Replies
  // ****************************************************************
  // Every frame is answered one cycle later; writes answer zero.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.rsp_valid <= 1'b0;
      link.rsp_data <= 32'h00000000;
    end
    else
    begin
      link.rsp_valid <= link.frm_valid;
      if (link.frm_valid && link.frm_cmd == stc_pkg::CMD_READ
          && link.frm_dno == stc_pkg::DNO_MODE_RD)
        link.rsp_data <= {29'h00000000, test_mode};
      else if (link.frm_valid && link.frm_cmd == stc_pkg::CMD_STATUS
               && link.frm_dno == stc_pkg::DNO_STATUS)
        link.rsp_data <= drive_status;
      else if (link.frm_valid)
        link.rsp_data <= 32'h00000000;
    end
  end

endmodule

/* verilog/stc_host.sv */
module stc_host #(
  parameter int KEEPALIVE_CYCLES = stc_pkg::KEEPALIVE_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Frame link.
  stc_link_if.host_mp link,
  // User request.
  input wire logic req_valid,
  input wire logic [7:0] req_cmd,
  input wire logic [7:0] req_dno,
  input wire logic [31:0] req_data,
  output logic req_ready,
  output logic req_refused,
  // User reply.
  output logic ans_valid,
  output logic [31:0] ans_data,
  // External input drive requested by the user, and what is driven.
  input wire logic [31:0] ext_request,
  output logic [31:0] ext_drive
);

  // ****************************************************************
  // Host state
  // ****************************************************************
  logic busy;                // A frame is out, reply awaited.
  logic poll_own;            // The frame out is a keep-alive poll.
  logic poll_status;         // The frame out reads the status word.
  logic out_dis_sent;        // Outputs disabled by our own command.
  logic homing_seen;         // Last status read showed homing done.
  logic test_on;             // A test mode was selected.
  logic [31:0] ext_keep;     // External bits not turned off by a word.
  logic [31:0] cnt_quiet;    // Idle cycles since the last request or poll.
  logic is_mode;
  logic bad_req;

  assign is_mode = req_cmd == stc_pkg::CMD_MODE_SEL
    && req_dno == stc_pkg::DNO_MODE_SEL;
  // Forced output needs outputs off first; single-step needs homing.
  assign bad_req = is_mode
    && ((req_data == 32'h00000004 && !out_dis_sent)
        || (req_data == 32'h00000005 && !homing_seen));

  // ****************************************************************
  // Frame issue
  // ****************************************************************
  // One frame at a time; idle gaps after a non-zero mode select are filled by polls.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      poll_own <= 1'b0;
      poll_status <= 1'b0;
      req_refused <= 1'b0;
      cnt_quiet <= 32'h00000000;
      link.frm_valid <= 1'b0;
      link.frm_cmd <= 8'h00;
      link.frm_dno <= 8'h00;
      link.frm_data <= 32'h00000000;
    end
    else
    begin
      link.frm_valid <= 1'b0;
      req_refused <= 1'b0;
      if (busy)
      begin
        if (link.rsp_valid)
          busy <= 1'b0;
      end
      else if (req_valid && req_ready)
      begin
        cnt_quiet <= 32'h00000000;
        if (bad_req)
          req_refused <= 1'b1;
        else
        begin
          busy <= 1'b1;
          poll_own <= 1'b0;
          poll_status <= req_cmd == stc_pkg::CMD_STATUS
            && req_dno == stc_pkg::DNO_STATUS;
          link.frm_valid <= 1'b1;
          link.frm_cmd <= req_cmd;
          link.frm_dno <= req_dno;
          link.frm_data <= req_data;
        end
      end
      else if (test_on && cnt_quiet >= KEEPALIVE_CYCLES)
      begin
        cnt_quiet <= 32'h00000000;
        busy <= 1'b1;
        poll_own <= 1'b1;
        poll_status <= 1'b1;
        link.frm_valid <= 1'b1;
        link.frm_cmd <= stc_pkg::CMD_STATUS;
        link.frm_dno <= stc_pkg::DNO_STATUS;
        link.frm_data <= 32'h00000000;
      end
      else
        cnt_quiet <= cnt_quiet + 32'h00000001;
    end
  end

  // Ready is registered: low while a frame is out, one just left or a
  // poll is due.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      req_ready <= 1'b0;
    else
      req_ready <= !busy && !link.frm_valid && !(req_valid && req_ready)
        && !(test_on && cnt_quiet >= KEEPALIVE_CYCLES);
  end

  // ****************************************************************
  // Tracking of what was sent
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_dis_sent <= 1'b0;
      test_on <= 1'b0;
      ext_keep <= 32'hFFFFFFFF;
    end
    else if (link.frm_valid)
    begin
      if (link.frm_cmd == stc_pkg::CMD_IO_DIS
          && link.frm_data == stc_pkg::IO_KEY)
      begin
        if (link.frm_dno == stc_pkg::DNO_DO_DIS)
          out_dis_sent <= 1'b1;
        else if (link.frm_dno == stc_pkg::DNO_DO_EN)
          out_dis_sent <= 1'b0;
      end
      if (link.frm_cmd == stc_pkg::CMD_MODE_SEL
          && link.frm_dno == stc_pkg::DNO_MODE_SEL)
        test_on <= link.frm_data != 32'h00000000;
      if (link.frm_cmd == stc_pkg::CMD_DEVICE
          && link.frm_dno == stc_pkg::DNO_WORD0)
        ext_keep <= link.frm_data;
    end
  end

  // ****************************************************************
  // Replies and external drive
  // ****************************************************************
  // Poll answers refresh the homing flag and ans_data but do not raise ans_valid.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      homing_seen <= 1'b0;
      ans_valid <= 1'b0;
      ans_data <= 32'h00000000;
      ext_drive <= 32'h00000000;
    end
    else
    begin
      ans_valid <= link.rsp_valid && busy && !poll_own;
      if (link.rsp_valid)
        ans_data <= link.rsp_data;
      if (link.rsp_valid && busy && poll_status)
        homing_seen <= link.rsp_data[stc_pkg::BIT_HOMING_DONE];
      ext_drive <= ext_request & ext_keep;
    end
  end

endmodule

/* bench/stc_link_props.sv */
// ****************
// Link checker
// ****************
module stc_link_props (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Frame and reply signals.
  input wire logic frm_valid,
  input wire logic [7:0] frm_cmd,
  input wire logic [7:0] frm_dno,
  input wire logic [31:0] frm_data,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Mode the device ought to hold, tracked from select frames.
  logic [2:0] sel_mode;
  logic is_sel;
  logic is_rd;
  assign is_sel = frm_valid && frm_cmd == stc_pkg::CMD_MODE_SEL
                  && frm_dno == stc_pkg::DNO_MODE_SEL;
  assign is_rd = frm_valid && frm_cmd == stc_pkg::CMD_READ
                 && frm_dno == stc_pkg::DNO_MODE_RD;
  // Motorless mode cannot be left by a zero code, so track that too.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sel_mode <= 3'h0;
    else if (is_sel && frm_data >= 32'h1 && frm_data <= 32'h5)
      sel_mode <= frm_data[2:0];
    else if (is_sel && frm_data == 32'h0 && sel_mode != 3'h3)
      sel_mode <= 3'h0;
  end
  a_reply_follows: assert property (frm_valid |=> rsp_valid)
    else $error("frame without reply");
  a_reply_needs_frame: assert property (rsp_valid |-> $past(frm_valid))
    else $error("reply without frame");
  a_mode_in_range: assert property (is_rd |=> rsp_data <= 32'h5)
    else $error("mode code out of range");
  a_mode_read_value: assert property
    (is_rd |=> rsp_data == {29'h0, $past(sel_mode)})
    else $error("mode read differs from selection");
  a_io_reply_zero: assert property
    (frm_valid && frm_cmd == stc_pkg::CMD_IO_DIS |=> rsp_data == 32'h0)
    else $error("disable frame reply not zero");
  a_pos_reply_zero: assert property
    (frm_valid && frm_cmd == stc_pkg::CMD_POS_CTRL |=> rsp_data == 32'h0)
    else $error("pause frame reply not zero");
  a_dev_reply_zero: assert property
    (frm_valid && frm_cmd == stc_pkg::CMD_DEVICE |=> rsp_data == 32'h0)
    else $error("device frame reply not zero");
  a_reply_holds: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("reply data moved between replies");
  c_select: cover property (is_sel ##1 rsp_valid);
  c_read: cover property (is_rd ##1 rsp_valid);
  c_pause: cover property (frm_valid && frm_data == stc_pkg::TXT_STOP);
endmodule

/* bench/servo_test_cmd_interp_bench.sv */
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("unexpected at %0t got %h want %h", $time, got, exp); \
    end \
  end
// ****************
// Bench top
// ****************
module servo_test_cmd_interp_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, req_valid, req_ready, req_refused, ans_valid;
  logic [7:0] req_cmd, req_dno;
  logic [31:0] req_data, ans_data, ext_request, ext_drive;
  logic emergency_stop_pin, motor_running, emergency_stop, analog_enable;
  logic [31:0] input_signals_pin, drive_outputs, drive_status;
  logic [31:0] dev_word0, dev_word1, output_pins;
  logic [2:0] test_mode;
  logic base_off, servo_lock_stop, pos_paused, pos_restart, pos_clear;
  logic refused;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_rst = 0;
  int n_clr = 0;
  logic [2:0] mlist [2] = '{3'h1, 3'h5};
  stc_link_if link();
  // Short watchdog and keep-alive so the run stays brief.
  stc_device #(.INACT_CYCLES(50)) u_stc_device (.clk_sys, .rst_n,
    .link(link), .emergency_stop_pin, .input_signals_pin, .motor_running,
    .drive_outputs, .drive_status, .emergency_stop, .dev_word0, .dev_word1,
    .analog_enable, .output_pins, .test_mode, .base_off, .servo_lock_stop,
    .pos_paused, .pos_restart, .pos_clear);
  stc_host #(.KEEPALIVE_CYCLES(20)) u_stc_host (.clk_sys, .rst_n,
    .link(link), .req_valid, .req_cmd, .req_dno, .req_data, .req_ready,
    .req_refused, .ans_valid, .ans_data, .ext_request, .ext_drive);
  stc_link_props u_stc_link_props (.clk_sys, .rst_n,
    .frm_valid(link.frm_valid), .frm_cmd(link.frm_cmd),
    .frm_dno(link.frm_dno), .frm_data(link.frm_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Restart and clear are single-cycle pulses, so count them here.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (pos_restart === 1'b1)
      n_rst++;
    if (pos_clear === 1'b1)
      n_clr++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // One user request; waits for the answer or the refusal pulse.
  task automatic send(input logic [7:0] c, input logic [7:0] d,
                      input logic [31:0] v);
    @(posedge clk_sys);
    req_cmd <= c;
    req_dno <= d;
    req_data <= v;
    req_valid <= 1'b1;
    do @(negedge clk_sys); while (req_ready !== 1'b1);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    do @(negedge clk_sys); while (ans_valid !== 1'b1 && req_refused !== 1'b1);
    refused = req_refused;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = 8'h00;
    req_dno = 8'h00;
    req_data = 32'h0;
    emergency_stop_pin = 1'b1;
    input_signals_pin = 32'hFFFFFFFF;
    motor_running = 1'b0;
    drive_outputs = 32'h000000FF;
    drive_status = 32'h00020000;
    ext_request = 32'hFFFFFFFF;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(4);
    `CHK(test_mode, stc_pkg::MODE_NORMAL)
    `CHK(output_pins, 32'h000000FF)
    send(stc_pkg::CMD_IO_DIS, stc_pkg::DNO_DI_DIS, stc_pkg::IO_KEY);
    `CHK(dev_word0, 32'h00000006)
    `CHK(emergency_stop, 1'b1)
    `CHK(analog_enable, 1'b0)
    send(stc_pkg::CMD_IO_DIS, stc_pkg::DNO_DI_EN, 32'h00001EA4);
    `CHK(dev_word0, 32'h00000006)
    send(stc_pkg::CMD_IO_DIS, stc_pkg::DNO_DI_EN, stc_pkg::IO_KEY);
    `CHK(dev_word0, 32'hFFFFFFFF)
    $display("input disable test done");
    @(posedge clk_sys);
    input_signals_pin <= 32'h0;
    tick(4);
    send(stc_pkg::CMD_DEVICE, stc_pkg::DNO_WORD0, 32'h09000001);
    `CHK(dev_word0, 32'h09000001)
    `CHK(ext_drive, 32'h09000001)
    send(stc_pkg::CMD_DEVICE, stc_pkg::DNO_WORD1, 32'hA5000000);
    `CHK(dev_word1, 32'hA5000000)
    send(stc_pkg::CMD_DEVICE, stc_pkg::DNO_WORD0, 32'h0);
    `CHK(dev_word0, 32'h0)
    send(stc_pkg::CMD_IO_DIS, stc_pkg::DNO_DO_DIS, stc_pkg::IO_KEY);
    `CHK(output_pins, 32'h0)
    send(stc_pkg::CMD_IO_DIS, stc_pkg::DNO_DO_EN, stc_pkg::IO_KEY);
    `CHK(output_pins, 32'h000000FF)
    $display("device word test done");
    send(stc_pkg::CMD_STATUS, stc_pkg::DNO_STATUS, 32'h0);
    `CHK(ans_data, 32'h00020000)
    @(posedge clk_sys);
    motor_running <= 1'b1;
    // Selecting from normal while running must coast the motor.
    foreach (mlist[i])
    begin
      send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, {29'h0, mlist[i]});
      `CHK(base_off, 1'b1)
      send(stc_pkg::CMD_READ, stc_pkg::DNO_MODE_RD, 32'h0);
      `CHK(ans_data, {29'h0, mlist[i]})
      send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h0);
    end
    @(posedge clk_sys);
    motor_running <= 1'b0;
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h2);
    send(stc_pkg::CMD_POS_CTRL, stc_pkg::DNO_POS_CTRL, stc_pkg::TXT_STOP);
    `CHK(pos_paused, 1'b1)
    send(stc_pkg::CMD_POS_CTRL, stc_pkg::DNO_POS_CTRL, stc_pkg::TXT_GO);
    `CHK(pos_paused, 1'b0)
    send(stc_pkg::CMD_POS_CTRL, stc_pkg::DNO_POS_CTRL, stc_pkg::TXT_STOP);
    send(stc_pkg::CMD_POS_CTRL, stc_pkg::DNO_POS_CTRL, stc_pkg::TXT_BLANK);
    `CHK(pos_paused, 1'b0)
    `CHK(n_rst, 1)
    `CHK(n_clr, 1)
    // Idle well past the watchdog; host keep-alive must prevent a stop.
    tick(200);
    `CHK(servo_lock_stop, 1'b0)
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h0);
    $display("positioning test done");
    @(posedge clk_sys);
    drive_status <= 32'h0;
    send(stc_pkg::CMD_STATUS, stc_pkg::DNO_STATUS, 32'h0);
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h5);
    `CHK(refused, 1'b1)
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h4);
    `CHK(refused, 1'b1)
    send(stc_pkg::CMD_IO_DIS, stc_pkg::DNO_DO_DIS, stc_pkg::IO_KEY);
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h4);
    `CHK(test_mode, stc_pkg::MODE_DO_FORCE)
    send(stc_pkg::CMD_DEVICE, stc_pkg::DNO_DO_FORCE, 32'h0000005A);
    `CHK(output_pins, 32'h0000005A)
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h0);
    `CHK(test_mode, stc_pkg::MODE_NORMAL)
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h3);
    `CHK(test_mode, stc_pkg::MODE_MOTORLESS)
    send(stc_pkg::CMD_MODE_SEL, stc_pkg::DNO_MODE_SEL, 32'h0);
    tick(100);
    `CHK(test_mode, stc_pkg::MODE_MOTORLESS)
    `CHK(servo_lock_stop, 1'b1)
    $display("mode test done");
    conclude();
  end
endmodule
